// File: sflg_pkg.sv
// sflg_pkg: constants, encodings and register layouts of the special status flags
// assumes one 10 MHz system clock and an ahb-lite bus with 32-bit data
`default_nettype none
package sflg_pkg;
    localparam int unsigned CLOCK_HZ = 10_000_000;
    // timebase half periods, each in its own unit
    localparam int unsigned MINUTE_HALF_S = 30;
    localparam int unsigned SECOND_HALF_MS = 500;
    localparam int unsigned TICK100_HALF_MS = 50;
    localparam int unsigned TICK50_HALF_MS = 25;
    localparam int unsigned MINUTE_HALF_CYC = MINUTE_HALF_S * CLOCK_HZ;
    localparam int unsigned SECOND_HALF_CYC = SECOND_HALF_MS * (CLOCK_HZ / 1000);
    localparam int unsigned TICK100_HALF_CYC = TICK100_HALF_MS * (CLOCK_HZ / 1000);
    localparam int unsigned TICK50_HALF_CYC = TICK50_HALF_MS * (CLOCK_HZ / 1000);
    // register byte offsets
    localparam logic [31:0] OFF_STATUS0 = 32'h0000_0000;
    localparam logic [31:0] OFF_STATUS1 = 32'h0000_0004;
    localparam logic [31:0] OFF_ACC = 32'h0000_0008;
    localparam logic [31:0] OFF_CODE = 32'h0000_000c;
    localparam logic [31:0] OFF_CTRL = 32'h0000_0010;
    // control register fields and reset value
    localparam int unsigned CTRL_CFG_CHECK_BIT = 0;
    localparam int unsigned CTRL_CLEAR_BIT = 1;
    localparam logic CFG_CHECK_RST = 1'b0;
    // ahb-lite encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    typedef enum logic [1:0] {
        SW_STOP = 2'h0,
        SW_RUN = 2'h1,
        SW_TERM = 2'h2
    } sflg_switch_e;
    typedef enum logic [1:0] {
        MODE_PROGRAM = 2'h0,
        MODE_RUN = 2'h1,
        MODE_TEST_RUN = 2'h2,
        MODE_TEST_PROGRAM = 2'h3
    } sflg_mode_e;
    typedef enum logic [2:0] {
        ACC_CMP = 3'h0,
        ACC_ADD16 = 3'h1,
        ACC_SUB16 = 3'h2,
        ACC_ADD32 = 3'h3,
        ACC_SUB32 = 3'h4,
        ACC_LOAD = 3'h5
    } sflg_acc_op_e;
    // field layouts, last field is bit 0
    typedef struct packed {
        logic [12:0] rsvd;
        logic battery_disabled_flag;
        logic irq_enabled_flag;
        logic break_flag_b;
        logic stop_instr_flag;
        logic switch_stop_flag;
        logic term_program_flag;
        logic test_program_flag;
        logic break_flag_a;
        logic term_test_run_flag;
        logic term_run_flag;
        logic switch_run_flag;
        logic odd_even_scan_flag;
        logic tick_50ms_flag;
        logic tick_100ms_flag;
        logic second_tick_flag;
        logic minute_tick_flag;
        logic constant_false_flag;
        logic constant_true_flag;
        logic first_scan_flag;
    } sflg_status0_s;
    typedef struct packed {
        logic [17:0] rsvd;
        logic math_ptr_fault_flag;
        logic table_overrun_flag;
        logic smart_module_fault_flag;
        logic solve_fault_flag;
        logic syntax_fault_flag;
        logic watchdog_expired_flag;
        logic fault_instr_flag;
        logic io_config_fault_flag;
        logic port_comm_fault_flag;
        logic io_fault_flag;
        logic memory_fault_flag;
        logic battery_low_flag;
        logic minor_fault_flag;
        logic critical_fault_flag;
    } sflg_status1_s;
    typedef struct packed {
        logic [16:0] rsvd;
        logic load_zero_flag;
        logic data_err_flag;
        logic underflow_flag;
        logic overflow_flag;
        logic float_flag;
        logic invalid_octal_flag;
        logic sign_flag;
        logic carry_flag;
        logic half_carry_flag;
        logic borrow_flag;
        logic half_borrow_flag;
        logic zero_flag;
        logic greater_flag;
        logic equal_flag;
        logic less_flag;
    } sflg_acc_s;
endpackage : sflg_pkg
`default_nettype wire

// File: sflg_timebase.sv
// sflg_timebase: free-running square wave, half period in clock cycles
// assumes a free-running clock; output starts low after reset
`default_nettype none
module sflg_timebase #(
    parameter int unsigned HALF_CYCLES = 2
) (
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // square wave
    output logic wave
);
    localparam logic [31:0] LAST = 32'(HALF_CYCLES - 1);
    typedef struct packed {
        logic [31:0] cnt;
        logic wave;
    } sflg_tb_s;
    sflg_tb_s st_reg;
    sflg_tb_s st_next;

    if (HALF_CYCLES < 1) begin : g_chk
        $error("half period must be at least one cycle");
    end

    always_comb begin
        st_next = st_reg;
        if (st_reg.cnt == LAST) begin
            st_next.cnt = 32'h0;
            st_next.wave = ~st_reg.wave;
        end else begin
            st_next.cnt = st_reg.cnt + 32'h1;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign wave = st_reg.wave;

    a_wave_phase: assert property (
        @(posedge clock) disable iff (!rstn)
        (st_reg.wave != $past(st_reg.wave)) |-> ($past(st_reg.cnt) == LAST))
        else $error("timebase toggled off its half period");
    a_count_bound: assert property (
        @(posedge clock) disable iff (!rstn)
        (st_reg.cnt <= LAST) and ((st_reg.cnt == LAST) |=> (st_reg.cnt == 32'h0)))
        else $error("timebase count out of range");
endmodule : sflg_timebase
`default_nettype wire

// File: sflg_top.sv
// sflg_top: special status flags of the controller cpu, read over ahb-lite
// assumes scan, mode and event inputs come from cpu logic on clock;
// switch and battery pins are asynchronous
//
// Local design decisions: the AHB-Lite interface to the registers and the register offsets.
`default_nettype none
module sflg_top #(
    parameter int unsigned MINUTE_HALF = sflg_pkg::MINUTE_HALF_CYC,
    parameter int unsigned SECOND_HALF = sflg_pkg::SECOND_HALF_CYC,
    parameter int unsigned TICK100_HALF = sflg_pkg::TICK100_HALF_CYC,
    parameter int unsigned TICK50_HALF = sflg_pkg::TICK50_HALF_CYC,
    parameter int unsigned CODE_W = 16
) (
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // scan and mode
    input wire logic scan_start,
    input wire logic [1:0] cpu_mode,
    // pins
    input wire logic [1:0] switch_pos,
    input wire logic battery_low_pin,
    // instruction events
    input wire logic break_instr,
    input wire logic stop_instr,
    input wire logic enable_interrupts_instr,
    input wire logic disable_interrupts_instr,
    input wire logic battery_disable,
    // fault events
    input wire logic io_comm_loss,
    input wire logic port_comm_err,
    input wire logic smart_module_err,
    input wire logic io_config_err,
    input wire logic fault_instr,
    input wire logic watchdog_expire,
    input wire logic parity_err,
    input wire logic io_err,
    input wire logic solve_err,
    input wire logic syntax_err,
    input wire logic [CODE_W-1:0] syntax_code,
    input wire logic table_ptr_overrun,
    input wire logic math_err,
    // accumulator results
    input wire logic acc_valid,
    input wire logic [2:0] acc_op,
    input wire logic [31:0] acc_a,
    input wire logic [31:0] acc_b,
    input wire logic acc_float,
    input wire logic acc_underflow,
    input wire logic acc_data_err,
    input wire logic acc_octal_err
);
    localparam int unsigned HALFS [4] = '{TICK50_HALF, TICK100_HALF, SECOND_HALF, MINUTE_HALF};

    typedef struct packed {
        logic [1:0] sw_meta;
        logic [1:0] sw_sync;
        logic bat_meta;
        logic bat_sync;
        logic first_pend;
        logic [1:0] prev_mode;
        sflg_pkg::sflg_status0_s s0;
        sflg_pkg::sflg_status1_s s1;
        sflg_pkg::sflg_acc_s ac;
        logic [CODE_W-1:0] code;
        logic cfg_check_en;
        logic wr_pend;
        logic [31:0] wr_addr;
        logic [31:0] hrdata;
        logic hreadyout;
        logic hresp;
    } sflg_top_s;

    sflg_top_s st_reg;
    sflg_top_s st_next;
    logic [3:0] tick;
    logic mode_chg;
    logic to_run;
    logic prog_to_run;
    logic clr;
    logic take;

    if (CODE_W < 1 || CODE_W > 32) begin : g_chk
        $error("syntax code width must be 1 to 32");
    end

    // free-running timebases
    for (genvar i = 0; i < 4; i++) begin : g_tick
        sflg_timebase #(.HALF_CYCLES(HALFS[i])) u_tb (
            .clock(clock), .rstn(rstn), .wave(tick[i]));
    end

    assign mode_chg = (cpu_mode != st_reg.prev_mode);
    assign to_run = mode_chg && (cpu_mode == sflg_pkg::MODE_RUN);
    assign prog_to_run = to_run && (st_reg.prev_mode == sflg_pkg::MODE_PROGRAM);
    assign clr = st_reg.wr_pend && (st_reg.wr_addr == sflg_pkg::OFF_CTRL)
        && hwdata[sflg_pkg::CTRL_CLEAR_BIT];
    assign take = hsel && hready && (htrans == sflg_pkg::HTRANS_NONSEQ)
        && (hsize == sflg_pkg::HSIZE_WORD);

    always_comb begin
        logic term;
        logic [32:0] sum;
        logic [31:0] res;
        logic ovf;
        logic neg;
        sflg_pkg::sflg_status1_s ev;
        term = 1'b0;
        sum = '0;
        res = '0;
        ovf = 1'b0;
        neg = 1'b0;
        ev = '0;
        st_next = st_reg;
        // pin synchronisers
        st_next.sw_meta = switch_pos;
        st_next.sw_sync = st_reg.sw_meta;
        st_next.bat_meta = battery_low_pin;
        st_next.bat_sync = st_reg.bat_meta;
        st_next.prev_mode = cpu_mode;
        // timebases run regardless of scan
        st_next.s0.tick_50ms_flag = tick[0];
        st_next.s0.tick_100ms_flag = tick[1];
        st_next.s0.second_tick_flag = tick[2];
        st_next.s0.minute_tick_flag = tick[3];
        st_next.s0.constant_true_flag = 1'b1;
        st_next.s0.constant_false_flag = 1'b0;
        // scan boundary
        if (scan_start) begin
            st_next.s0.first_scan_flag = st_reg.first_pend;
            st_next.first_pend = 1'b0;
            st_next.s0.odd_even_scan_flag = ~st_reg.s0.odd_even_scan_flag;
            st_next.s0.switch_run_flag = (st_reg.sw_sync == sflg_pkg::SW_RUN);
            st_next.s0.switch_stop_flag = (st_reg.sw_sync == sflg_pkg::SW_STOP);
            term = (st_reg.sw_sync == sflg_pkg::SW_TERM);
            st_next.s0.term_run_flag = term && (cpu_mode == sflg_pkg::MODE_RUN);
            st_next.s0.term_test_run_flag = term && (cpu_mode == sflg_pkg::MODE_TEST_RUN);
            st_next.s0.term_program_flag = term && (cpu_mode == sflg_pkg::MODE_PROGRAM);
            st_next.s0.test_program_flag = term && (cpu_mode == sflg_pkg::MODE_TEST_PROGRAM);
        end
        if (prog_to_run) begin
            st_next.first_pend = 1'b1;
        end
        // instruction driven flags
        st_next.s0.break_flag_a = break_instr || (st_reg.s0.break_flag_a && !mode_chg);
        st_next.s0.break_flag_b = break_instr || (st_reg.s0.break_flag_b && !to_run);
        st_next.s0.stop_instr_flag = stop_instr || (st_reg.s0.stop_instr_flag && !to_run);
        st_next.s0.irq_enabled_flag = enable_interrupts_instr
            || (st_reg.s0.irq_enabled_flag && !disable_interrupts_instr);
        st_next.s0.battery_disabled_flag = battery_disable;
        // sticky faults except battery_low_flag, set wins over clear
        ev.critical_fault_flag = io_comm_loss;
        ev.minor_fault_flag = st_reg.bat_sync || port_comm_err;
        ev.port_comm_fault_flag = port_comm_err;
        ev.smart_module_fault_flag = smart_module_err;
        ev.io_config_fault_flag = io_config_err;
        ev.syntax_fault_flag = syntax_err;
        ev.watchdog_expired_flag = watchdog_expire;
        ev.fault_instr_flag = fault_instr;
        ev.memory_fault_flag = parity_err;
        ev.io_fault_flag = io_err;
        ev.solve_fault_flag = solve_err;
        ev.table_overrun_flag = table_ptr_overrun;
        ev.math_ptr_fault_flag = math_err || table_ptr_overrun;
        st_next.s1 = ev | (st_reg.s1 & ~{32{clr}});
        st_next.s1.battery_low_flag = st_reg.bat_sync;
        if (!st_reg.cfg_check_en) begin
            st_next.s1.io_config_fault_flag = 1'b0;
        end
        if (syntax_err) begin
            st_next.code = syntax_code;
        end
        // accumulator condition flags
        if (acc_valid) begin
            st_next.ac = '0;
            case (acc_op)
                sflg_pkg::ACC_CMP: begin
                    st_next.ac.less_flag = (acc_a < acc_b);
                    st_next.ac.equal_flag = (acc_a == acc_b);
                    st_next.ac.greater_flag = (acc_a > acc_b);
                    res = acc_a - acc_b;
                    neg = acc_a[31];
                end
                sflg_pkg::ACC_ADD16: begin
                    sum = {16'h0, {1'b0, acc_a[15:0]} + {1'b0, acc_b[15:0]}};
                    st_next.ac.half_carry_flag = sum[16];
                    res = {16'h0, sum[15:0]};
                    neg = sum[15];
                    ovf = (acc_a[15] == acc_b[15]) && (sum[15] != acc_a[15]);
                end
                sflg_pkg::ACC_SUB16: begin
                    sum = {16'h0, {1'b0, acc_a[15:0]} - {1'b0, acc_b[15:0]}};
                    st_next.ac.half_borrow_flag = sum[16];
                    res = {16'h0, sum[15:0]};
                    neg = sum[15];
                    ovf = (acc_a[15] != acc_b[15]) && (sum[15] != acc_a[15]);
                end
                sflg_pkg::ACC_ADD32: begin
                    sum = {1'b0, acc_a} + {1'b0, acc_b};
                    st_next.ac.carry_flag = sum[32];
                    res = sum[31:0];
                    neg = sum[31];
                    ovf = (acc_a[31] == acc_b[31]) && (sum[31] != acc_a[31]);
                end
                sflg_pkg::ACC_SUB32: begin
                    sum = {1'b0, acc_a} - {1'b0, acc_b};
                    st_next.ac.borrow_flag = sum[32];
                    res = sum[31:0];
                    neg = sum[31];
                    ovf = (acc_a[31] != acc_b[31]) && (sum[31] != acc_a[31]);
                end
                sflg_pkg::ACC_LOAD: begin
                    res = acc_b;
                    neg = acc_b[31];
                    st_next.ac.load_zero_flag = (acc_b == 32'h0);
                end
                default: begin
                    res = acc_a;
                    neg = acc_a[31];
                end
            endcase
            st_next.ac.zero_flag = (res == 32'h0);
            st_next.ac.sign_flag = neg;
            st_next.ac.overflow_flag = ovf;
            st_next.ac.float_flag = acc_float;
            st_next.ac.underflow_flag = acc_underflow;
            st_next.ac.data_err_flag = acc_data_err;
            st_next.ac.invalid_octal_flag = acc_octal_err;
        end
        // ahb-lite slave, zero wait states
        st_next.wr_pend = 1'b0;
        if (st_reg.wr_pend && (st_reg.wr_addr == sflg_pkg::OFF_CTRL)) begin
            st_next.cfg_check_en = hwdata[sflg_pkg::CTRL_CFG_CHECK_BIT];
        end
        if (take && hwrite) begin
            st_next.wr_pend = 1'b1;
            st_next.wr_addr = haddr;
        end else if (take && (haddr == sflg_pkg::OFF_STATUS0)) begin
            st_next.hrdata = st_reg.s0;
        end else if (take && (haddr == sflg_pkg::OFF_STATUS1)) begin
            st_next.hrdata = st_reg.s1;
        end else if (take && (haddr == sflg_pkg::OFF_ACC)) begin
            st_next.hrdata = st_reg.ac;
        end else if (take && (haddr == sflg_pkg::OFF_CODE)) begin
            st_next.hrdata = 32'(st_reg.code);
        end else if (take && (haddr == sflg_pkg::OFF_CTRL)) begin
            st_next.hrdata = 32'(st_reg.cfg_check_en) << sflg_pkg::CTRL_CFG_CHECK_BIT;
        end else if (take) begin
            st_next.hrdata = 32'h0;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            st_reg <= '0;
            st_reg.first_pend <= 1'b1;
            st_reg.s0.constant_true_flag <= 1'b1;
            st_reg.cfg_check_en <= sflg_pkg::CFG_CHECK_RST;
            st_reg.hreadyout <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign hreadyout = st_reg.hreadyout;
    assign hresp = st_reg.hresp;
    assign hrdata = st_reg.hrdata;

    a_first_once: assert property (
        @(posedge clock) disable iff (!rstn)
        (scan_start && st_reg.first_pend && !prog_to_run)
        |=> (st_reg.s0.first_scan_flag && !st_reg.first_pend))
        else $error("first scan flag not shown once");
    a_first_clear: assert property (
        @(posedge clock) disable iff (!rstn)
        scan_start |=> (st_reg.s0.first_scan_flag == $past(st_reg.first_pend)))
        else $error("first scan flag wrong after scan start");
    a_const_read: assert property (
        @(posedge clock) disable iff (!rstn)
        (take && !hwrite && (haddr == sflg_pkg::OFF_STATUS0))
        |=> ((hrdata == 32'($past(st_reg.s0))) && st_reg.s0.constant_true_flag
            && !st_reg.s0.constant_false_flag))
        else $error("status read or constant flags wrong");
    a_scan_toggle: assert property (
        @(posedge clock) disable iff (!rstn)
        scan_start |=> (st_reg.s0.odd_even_scan_flag != $past(st_reg.s0.odd_even_scan_flag)))
        else $error("alternate scan flag did not toggle");
    a_switch_flags: assert property (
        @(posedge clock) disable iff (!rstn)
        scan_start |=> ((st_reg.s0.switch_run_flag == ($past(st_reg.sw_sync) == 2'h1))
            && (st_reg.s0.switch_stop_flag == ($past(st_reg.sw_sync) == 2'h0))))
        else $error("switch position flags wrong");
    a_term_onehot: assert property (
        @(posedge clock) disable iff (!rstn)
        (scan_start && (st_reg.sw_sync == sflg_pkg::SW_TERM))
        |=> $onehot({st_reg.s0.term_run_flag, st_reg.s0.term_test_run_flag,
            st_reg.s0.term_program_flag, st_reg.s0.test_program_flag}))
        else $error("terminal mode flags not one-hot");
    a_break_flags: assert property (
        @(posedge clock) disable iff (!rstn)
        (break_instr |=> (st_reg.s0.break_flag_a && st_reg.s0.break_flag_b))
        and ((st_reg.s0.break_flag_b && !to_run) |=> st_reg.s0.break_flag_b))
        else $error("break flags wrong");
    a_stop_set: assert property (
        @(posedge clock) disable iff (!rstn)
        stop_instr |=> st_reg.s0.stop_instr_flag [*1])
        else $error("stop flag not set");
    a_cfg_gate: assert property (
        @(posedge clock) disable iff (!rstn)
        (!st_reg.cfg_check_en |=> !st_reg.s1.io_config_fault_flag)
        and ((st_reg.cfg_check_en && io_config_err) |=> st_reg.s1.io_config_fault_flag))
        else $error("config fault flag not gated by check enable");
    a_syntax_code: assert property (
        @(posedge clock) disable iff (!rstn)
        syntax_err |=> (st_reg.s1.syntax_fault_flag && (st_reg.code == $past(syntax_code))))
        else $error("syntax code not stored");
    a_sticky_fault: assert property (
        @(posedge clock) disable iff (!rstn)
        (watchdog_expire || (st_reg.s1.watchdog_expired_flag && !clr))
        |=> st_reg.s1.watchdog_expired_flag)
        else $error("watchdog flag lost");
    a_cmp_onehot: assert property (
        @(posedge clock) disable iff (!rstn)
        (acc_valid && (acc_op == sflg_pkg::ACC_CMP))
        |=> $onehot({st_reg.ac.less_flag, st_reg.ac.equal_flag, st_reg.ac.greater_flag}))
        else $error("compare flags not one-hot");
    a_half_carry: assert property (
        @(posedge clock) disable iff (!rstn)
        (acc_valid && (acc_op == sflg_pkg::ACC_ADD16))
        |=> (st_reg.ac.half_carry_flag == ((17'($past(acc_a[15:0]))
            + 17'($past(acc_b[15:0]))) > 17'h0ffff)))
        else $error("half carry wrong");
endmodule : sflg_top
`default_nettype wire

// File: tb_top.sv
// tb_top: self-checking bench of the special status flags over ahb-lite
// assumes sflg_top with shortened timebase halves on a 10 MHz clock
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin mismatches++; \
    $display("BAD %0t %h %h", $time, a, e); end end
    logic clock = 0, rstn = 0, hsel = 0, hwrite = 0, scan = 0, vld = 0, bpin = 0, bdis = 0;
    logic [1:0] htrans = 0, mode = 0, sw = 0;
    logic [2:0] op = 0;
    logic [31:0] haddr = 0, hwdata = 0, a = 0, b = 0, d, p, q;
    logic [15:0] code = 0;
    logic [11:0] ev = 0;
    logic [3:0] ins = 0, af = 0;
    wire logic hrdy, hresp;
    wire logic [31:0] hrdata;
    int mismatches = 0, num_checks = 0, sh[4] = '{4, 0, 1, 3};
    int cyc = 0, t = 0;
    logic [13:0] m1[12] = '{14'h1, 14'h22, 14'h800, 14'h40, 14'h80, 14'h100, 14'h8, 14'h10,
        14'h400, 14'h200, 14'h3000, 14'h2000};
    sflg_top #(.MINUTE_HALF(8), .SECOND_HALF(4), .TICK100_HALF(2), .TICK50_HALF(1)) dut (
        .clock, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hrdy),
        .hreadyout(hrdy), .hresp, .hrdata, .scan_start(scan), .cpu_mode(mode),
        .switch_pos(sw), .battery_low_pin(bpin), .break_instr(ins[0]), .stop_instr(ins[1]),
        .enable_interrupts_instr(ins[2]), .disable_interrupts_instr(ins[3]),
        .battery_disable(bdis), .io_comm_loss(ev[0]), .port_comm_err(ev[1]),
        .smart_module_err(ev[2]), .io_config_err(ev[3]), .fault_instr(ev[4]),
        .watchdog_expire(ev[5]), .parity_err(ev[6]), .io_err(ev[7]), .solve_err(ev[8]),
        .syntax_err(ev[9]), .syntax_code(code), .table_ptr_overrun(ev[10]), .math_err(ev[11]),
        .acc_valid(vld), .acc_op(op), .acc_a(a), .acc_b(b), .acc_float(af[0]),
        .acc_underflow(af[1]), .acc_data_err(af[2]), .acc_octal_err(af[3]));
    function automatic logic [31:0] cmp_exp(input logic [31:0] x, y);
        return 32'({x[31], 4'h0, x == y, x > y, x == y, x < y});
    endfunction : cmp_exp
    // timebase levels k edges after reset, halves of 1, 2, 4 and 8 cycles
    function automatic logic [3:0] tick_exp(input int k);
        return {k % 2 == 1, (k / 2) % 2 == 1, (k / 4) % 2 == 1, (k / 8) % 2 == 1};
    endfunction : tick_exp
    task automatic bus(input logic w, input logic [31:0] ad, wd);
        @(posedge clock);
        {hsel, htrans, hwrite, haddr} <= {1'b1, sflg_pkg::HTRANS_NONSEQ, w, ad};
        do @(posedge clock); while (hrdy !== 1'b1);
        t = cyc;
        {hsel, htrans, hwdata} <= {1'b0, 2'h0, wd};
        do @(posedge clock); while (hrdy !== 1'b1);
        d = hrdata;
    endtask : bus
    task automatic rd0;
        bus(0, sflg_pkg::OFF_STATUS0, 0);
        `CHK(d[6:3], tick_exp(t - 1))
    endtask : rd0
    task automatic pulse(input logic s, input logic [3:0] i, input logic [11:0] e);
        repeat (3) @(posedge clock);
        {scan, ins, ev} <= {s, i, e};
        @(posedge clock);
        {scan, ins, ev} <= 17'h0;
    endtask : pulse
    task automatic acc(input logic [2:0] o, input logic [31:0] x, y, m, e);
        @(posedge clock);
        {vld, op, a, b} <= {1'b1, o, x, y};
        @(posedge clock);
        vld <= 0;
        bus(0, sflg_pkg::OFF_ACC, 0);
        `CHK(d & m, e)
    endtask : acc
    task automatic final_report;
        if (mismatches == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : final_report
    initial forever #50 clock = ~clock;
    always @(posedge clock) cyc <= rstn ? cyc + 1 : 0;
    initial begin
        #1ms;
        mismatches++;
        final_report;
    end
    initial begin
        void'($urandom(32'h5fc3));
        repeat (4) @(posedge clock);
        rstn <= 1;
        {sw, mode} <= {sflg_pkg::SW_RUN, sflg_pkg::MODE_RUN};
        rd0;
        `CHK(d[2:1], 2'h1)
        pulse(1, 0, 0);
        rd0;
        `CHK({d[8], d[0]}, 2'h3)
        p = d;
        pulse(1, 0, 0);
        rd0;
        `CHK({d[7], d[0]}, {~p[7], 1'b0})
        p = d;
        rd0;
        `CHK(d[6], ~p[6])
        sw <= sflg_pkg::SW_TERM;
        for (int m = 0; m < 4; m++) begin
            mode <= m[1:0];
            pulse(1, 0, 0);
            rd0;
            `CHK({d[13:9] & 5'h1b, d[0]}, {5'h1 << sh[m], m == 1})
        end
        sw <= sflg_pkg::SW_STOP;
        pulse(1, 4'h3, 0);
        rd0;
        `CHK({d[16:14], d[11], d[8]}, 5'h1e)
        mode <= sflg_pkg::MODE_TEST_RUN;
        pulse(0, 0, 0);
        rd0;
        `CHK({d[16:15], d[11]}, 3'h6)
        {mode, bdis} <= {sflg_pkg::MODE_RUN, 1'b1};
        pulse(0, 4'h4, 0);
        rd0;
        `CHK({d[18:15], d[11]}, 5'h18)
        pulse(0, 4'h8, 0);
        rd0;
        `CHK(d[17], 1'b0)
        for (int c = 0; c < 2; c++) begin
            for (int i = 0; i < 12; i++) begin
                bus(1, sflg_pkg::OFF_CTRL, 32'h2 | c);
                pulse(0, 0, 12'h1 << i);
                bus(0, sflg_pkg::OFF_STATUS1, 0);
                `CHK(d[13:0], (i == 3 && c == 0) ? 14'h0 : m1[i])
            end
        end
        {code, bpin} <= {16'($urandom), 1'b1};
        pulse(0, 0, 12'h200);
        bus(0, sflg_pkg::OFF_STATUS1, 0);
        `CHK(d[2:1], 2'h3)
        bus(0, sflg_pkg::OFF_CODE, 0);
        `CHK(d[15:0], code)
        bus(0, sflg_pkg::OFF_CTRL, 0);
        `CHK(d, 32'h1)
        bus(0, 32'h20, 0);
        `CHK({hresp, d}, 33'h0)
        for (int i = 0; i < 16; i++) begin
            p = $urandom;
            q = i[0] ? p : $urandom;
            acc(sflg_pkg::ACC_CMP, p, q, 32'h1ff, cmp_exp(p, q));
        end
        acc(sflg_pkg::ACC_ADD16, 32'hffff, 1, 32'h40, 32'h40);
        acc(sflg_pkg::ACC_SUB16, 0, 1, 32'h110, 32'h110);
        acc(sflg_pkg::ACC_ADD32, 32'hffffffff, 1, 32'h88, 32'h88);
        acc(sflg_pkg::ACC_SUB32, 0, 1, 32'h120, 32'h120);
        acc(sflg_pkg::ACC_ADD32, 32'h7fffffff, 1, 32'h980, 32'h900);
        acc(sflg_pkg::ACC_LOAD, 0, 0, 32'h4000, 32'h4000);
        acc(3'h7, 32'h80000000, 5, 32'h7fff, 32'h100);
        af <= 4'hf;
        acc(sflg_pkg::ACC_LOAD, 0, 5, 32'h3600, 32'h3600);
        final_report;
    end
endmodule : tb_top
`default_nettype wire
